//--- design/gate_relay_defs.svh
`ifndef GATE_RELAY_DEFS_SVH
`define GATE_RELAY_DEFS_SVH

// function codes held per relay
`define FN_MOTOR_RUNNING    6'h10
`define FN_DC_POWER_ALERT   6'h19
`define FN_EXIT_PULSE       6'h1a
`define FN_NOT_OPEN_AC      6'h1b
`define FN_FLASHER_AC       6'h1c
`define FN_INERT_FIRST      6'h1d
`define FN_INERT_LAST       6'h28
`define FN_TEST_OPEN_PULSE  6'h29
`define FN_BREAKAWAY        6'h2a
`define FN_WARN_BEFORE      6'h2b
`define FN_PARTIAL_PULSE    6'h2c
`define FN_OUTSIDE_LOOP     6'h2d

// field widths
`define FUNC_CODE_W         6

// timing, times in milliseconds, counts in clock cycles
`define CLK_HZ              100000000
`define PULSE_MS            250
`define TEST_DELAY_MS       5000
`define FLASH_HALF_MS       500
`define PULSE_CYC           ((`CLK_HZ / 1000) * `PULSE_MS)
`define TEST_DELAY_CYC      ((`CLK_HZ / 1000) * `TEST_DELAY_MS)
`define FLASH_HALF_CYC      ((`CLK_HZ / 1000) * `FLASH_HALF_MS)

`endif

//--- design/gate_relay_pkg.sv
`include "gate_relay_defs.svh"

package gate_relay_pkg;

    typedef logic [`FUNC_CODE_W-1:0] func_code_t;

    // gate status inputs, all active high
    typedef struct packed {
        logic ac_present;
        logic batt_above_21v;
        logic open_limit;
        logic close_limit;
        logic partial_limit_reached;
        logic partial_open_cmd;
        logic partial_open_input;
        logic free_exit_trip;
        logic breakaway_trip;
        logic motor_running;
        logic gate_moving;
        logic outside_obstruction_loop_trip;
        logic outside_arming_loop_trip;
        logic warn_before_active;
    } gate_status_t;

    // cycle test delay sequencer
    typedef enum logic [2:0] {
        TEST_IDLE = 3'h1,
        TEST_WAIT = 3'h2,
        TEST_HELD = 3'h4
    } test_state_t;

endpackage : gate_relay_pkg

//--- design/relay_pulse_timer.sv
`include "gate_relay_defs.svh"

module relay_pulse_timer #(
    parameter int unsigned LEN = `PULSE_CYC
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic ce,
    input  wire logic trig,
    output logic      active
);

    logic [31:0] remain;

    // a new trigger restarts the full length
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            active <= 1'b0;
            remain <= 32'h0;
        end else if (ce) begin
            if (trig) begin
                active <= 1'b1;
                remain <= 32'(LEN - 1);
            end else if (active) begin
                if (remain == 32'h0) begin
                    active <= 1'b0;
                end else begin
                    remain <= remain - 32'h1;
                end
            end
        end
    end

    pulse_start_a : assert property ( // R14
        @(posedge clk) disable iff (!arst_n)
        (ce && trig) |=> (active && remain == 32'(LEN - 1)))
        else $error("pulse did not start with full length");

    pulse_end_a : assert property ( // R14
        @(posedge clk) disable iff (!arst_n)
        (ce && active && !trig && remain == 32'h0) |=> !active)
        else $error("pulse did not end when count ran out");

endmodule : relay_pulse_timer

//--- design/gate_relay_function_select.sv
`include "gate_relay_defs.svh"

// Operation
// R1: code 25 drives relay while AC present or battery above 21V.
// R2: code 25 suits relay 2 to shed loads while on battery.
// R3: code 26 gives one 250ms pulse per free exit loop trip.
// R4: code 27 drives relay while off open limit with AC present.
// R5: code 28 flashes 500ms halves while off open limit with AC.
// R6: codes 29 to 40 never activate the relay.
// R7: code 41 pulses five seconds after close limit becomes active.
// R8: code 42 follows the arm break-away switch trip.
// R9: code 43 is warn-before or motor-running output, either active.
// R10: code 44 pulses 250ms on partial open limit events.
// R11: code 45 drives relay while outside loop tripped and gate closed.
// R12: motor-running meaning is motor running and gate moving.
// R13: flasher toggles every 500ms except while on open limit.
// R14: test pulse lasts 250ms; unknown codes drive relay inactive.
module gate_relay_function_select #(
    parameter int          NUM_RELAYS        = 2,
    parameter int unsigned PULSE_CYCLES      = `PULSE_CYC,
    parameter int unsigned TEST_DELAY_CYCLES = `TEST_DELAY_CYC,
    parameter int unsigned FLASH_HALF_CYCLES = `FLASH_HALF_CYC
) (
    input  wire logic                                     clk,
    input  wire logic                                     arst_n,
    input  wire logic                                     ce,
    input  wire gate_relay_pkg::gate_status_t             status,
    input  wire gate_relay_pkg::func_code_t [NUM_RELAYS-1:0] relay_func,
    output logic [NUM_RELAYS-1:0]                         relay_out
);

    gate_relay_pkg::gate_status_t prev;
    gate_relay_pkg::test_state_t  test_state;
    logic [31:0]                  test_cnt;
    logic                         test_fire;
    logic [31:0]                  flash_cnt;
    logic                         flash_phase;
    logic                         exit_rise;
    logic                         partial_trig;
    logic                         exit_pulse;
    logic                         test_pulse;
    logic                         partial_pulse;
    logic                         motor_run_fn;
    logic [NUM_RELAYS-1:0]        next_relay_out;

    // previous inputs for edge detection, only advanced with ce
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev <= '0;
        end else if (ce) begin
            prev <= status;
        end
    end

    // edge events feeding the pulse timers
    assign exit_rise    = status.free_exit_trip & ~prev.free_exit_trip; // R3
    assign partial_trig = (status.partial_open_cmd & status.partial_limit_reached
                           & ~prev.partial_limit_reached)
                        | (status.partial_open_input & ~prev.partial_open_input
                           & status.partial_limit_reached); // R10
    assign motor_run_fn = status.motor_running & status.gate_moving; // R12

    // flasher; phase forced low on open limit so each run starts dark
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flash_cnt   <= 32'h0;
            flash_phase <= 1'b0;
        end else if (ce) begin
            if (status.open_limit) begin
                flash_cnt   <= 32'h0; // R13
                flash_phase <= 1'b0;
            end else if (flash_cnt == 32'(FLASH_HALF_CYCLES - 1)) begin
                flash_cnt   <= 32'h0;
                flash_phase <= ~flash_phase; // R13
            end else begin
                flash_cnt   <= flash_cnt + 32'h1;
            end
        end
    end

    // cycle test sequencer: one shot per close limit arrival
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            test_state <= gate_relay_pkg::TEST_IDLE;
            test_cnt   <= 32'h0;
            test_fire  <= 1'b0;
        end else if (ce) begin
            test_fire <= 1'b0;
            case (test_state)
                gate_relay_pkg::TEST_IDLE: begin
                    test_cnt <= 32'h0;
                    if (status.close_limit && !prev.close_limit) begin
                        test_state <= gate_relay_pkg::TEST_WAIT; // R7
                    end
                end
                gate_relay_pkg::TEST_WAIT: begin
                    // leaving the close limit early cancels the shot
                    if (!status.close_limit) begin
                        test_state <= gate_relay_pkg::TEST_IDLE;
                    end else if (test_cnt == 32'(TEST_DELAY_CYCLES - 1)) begin
                        test_fire  <= 1'b1; // R7
                        test_state <= gate_relay_pkg::TEST_HELD;
                    end else begin
                        test_cnt <= test_cnt + 32'h1;
                    end
                end
                gate_relay_pkg::TEST_HELD: begin
                    if (!status.close_limit) begin
                        test_state <= gate_relay_pkg::TEST_IDLE;
                    end
                end
                default: begin
                    test_state <= gate_relay_pkg::TEST_IDLE;
                end
            endcase
        end
    end

    // shared pulse timers, one per pulsed function
    relay_pulse_timer #(
        .LEN    (PULSE_CYCLES)
    ) u_exit_pulse (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .trig   (exit_rise),
        .active (exit_pulse)
    );

    relay_pulse_timer #(
        .LEN    (PULSE_CYCLES)
    ) u_test_pulse (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .trig   (test_fire),
        .active (test_pulse)
    );

    relay_pulse_timer #(
        .LEN    (PULSE_CYCLES)
    ) u_partial_pulse (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .trig   (partial_trig),
        .active (partial_pulse)
    );

    // relay drive registered as one vector so each bit has a single driver
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            relay_out <= '0;
        end else if (ce) begin
            relay_out <= next_relay_out;
        end
    end

    // per relay function decode, registered so relays never glitch
    for (genvar i = 0; i < NUM_RELAYS; i++) begin : g_relay
        logic next_relay;

        always_comb begin
            case (relay_func[i])
                `FN_DC_POWER_ALERT:
                    next_relay = status.ac_present | status.batt_above_21v; // R1 R2
                `FN_EXIT_PULSE:
                    next_relay = exit_pulse; // R3
                `FN_NOT_OPEN_AC:
                    next_relay = ~status.open_limit & status.ac_present; // R4
                `FN_FLASHER_AC:
                    next_relay = flash_phase & ~status.open_limit
                               & status.ac_present; // R5
                `FN_TEST_OPEN_PULSE:
                    next_relay = test_pulse; // R7 R14
                `FN_BREAKAWAY:
                    next_relay = status.breakaway_trip; // R8
                `FN_WARN_BEFORE:
                    next_relay = status.warn_before_active | motor_run_fn; // R9
                `FN_PARTIAL_PULSE:
                    next_relay = partial_pulse; // R10
                `FN_OUTSIDE_LOOP:
                    next_relay = (status.outside_obstruction_loop_trip
                                | status.outside_arming_loop_trip)
                               & status.close_limit; // R11
                default:
                    next_relay = 1'b0; // R6 R14
            endcase
        end

        assign next_relay_out[i] = next_relay;

        dc_alert_a : assert property ( // R1
            @(posedge clk) disable iff (!arst_n)
            (ce && relay_func[i] == `FN_DC_POWER_ALERT)
            |=> relay_out[i] == ($past(status.ac_present) | $past(status.batt_above_21v)))
            else $error("dc power alert relay wrong");

        inert_codes_a : assert property ( // R6
            @(posedge clk) disable iff (!arst_n)
            (ce && relay_func[i] >= `FN_INERT_FIRST && relay_func[i] <= `FN_INERT_LAST)
            |=> !relay_out[i])
            else $error("inert code activated relay");

        not_open_a : assert property ( // R4
            @(posedge clk) disable iff (!arst_n)
            (ce && relay_func[i] == `FN_NOT_OPEN_AC)
            |=> relay_out[i] == (!$past(status.open_limit) && $past(status.ac_present)))
            else $error("not open relay wrong");

        flasher_gate_a : assert property ( // R5
            @(posedge clk) disable iff (!arst_n)
            (ce && relay_func[i] == `FN_FLASHER_AC
             && (status.open_limit || !status.ac_present))
            |=> !relay_out[i])
            else $error("flasher relay on while gated off");

        warn_before_a : assert property ( // R9
            @(posedge clk) disable iff (!arst_n)
            (ce && relay_func[i] == `FN_WARN_BEFORE && status.motor_running
             && status.gate_moving)
            |=> relay_out[i])
            else $error("warn before relay missed motor running");

        outside_loop_a : assert property ( // R11
            @(posedge clk) disable iff (!arst_n)
            (ce && relay_func[i] == `FN_OUTSIDE_LOOP && !status.close_limit)
            |=> !relay_out[i])
            else $error("outside loop relay on while gate not closed");

        exit_pulse_a : assert property ( // R3
            @(posedge clk) disable iff (!arst_n)
            (ce && relay_func[i] == `FN_EXIT_PULSE && exit_rise)
            ##1 (ce && relay_func[i] == `FN_EXIT_PULSE) |=> relay_out[i])
            else $error("exit pulse did not reach relay");
    end

    test_fire_a : assert property ( // R7
        @(posedge clk) disable iff (!arst_n)
        (ce && test_state == gate_relay_pkg::TEST_WAIT && status.close_limit
         && test_cnt == 32'(TEST_DELAY_CYCLES - 1))
        |=> test_fire && test_state == gate_relay_pkg::TEST_HELD)
        else $error("test pulse not fired at delay end");

    flash_hold_a : assert property ( // R13
        @(posedge clk) disable iff (!arst_n)
        (ce && status.open_limit) |=> (!flash_phase && flash_cnt == 32'h0))
        else $error("flasher running on open limit");

endmodule : gate_relay_function_select

//--- dv/relay_load_model.sv
// external relay load: counts pull-ins and the length of the last energised spell
module relay_coil_model (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic drive,
    output int        rises,
    output int        last_width
);
    timeunit 1ns;
    timeprecision 1ps;

    int   run;
    logic prev;

    // widths are in clock cycles, so frozen cycles show up in the count
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rises      <= 0;
            last_width <= 0;
            run        <= 0;
            prev       <= 1'b0;
        end else begin
            prev <= drive;
            if (drive) begin
                run <= run + 1;
            end
            if (drive && !prev) begin
                rises <= rises + 1;
            end
            if (!drive && prev) begin
                last_width <= run;
                run        <= 0;
            end
        end
    end
endmodule : relay_coil_model

//--- dv/testbench.sv
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                             clk;
    logic                             arst_n;
    logic                             ce;
    gate_relay_pkg::gate_status_t     st;
    gate_relay_pkg::func_code_t [1:0] fn;
    logic [1:0]                       rly;
    int                               rises;
    int                               width;
    int                               failures;
    int                               compares;

    // short counts keep the run small: pulse 5, delay 20, half flash 4
    gate_relay_function_select #(
        .NUM_RELAYS(2), .PULSE_CYCLES(5), .TEST_DELAY_CYCLES(20), .FLASH_HALF_CYCLES(4)
    ) dut (
        .clk(clk), .arst_n(arst_n), .ce(ce), .status(st), .relay_func(fn), .relay_out(rly)
    );

    relay_coil_model load (
        .clk(clk), .arst_n(arst_n), .drive(rly[0]), .rises(rises), .last_width(width)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic tally_and_finish;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    // relay 1 stays on code 25 throughout, so it is judged on every level step
    task automatic lvl(input logic [5:0] code, input logic [13:0] s, input logic e);
        fn[0] <= code;
        st    <= s;
        cyc(3);
        #1;
        `CHK(rly[0], e)
        `CHK(rly[1], s[13] | s[12])
        @(posedge clk);
    endtask : lvl

    // bounded wait for relay 0 to pull in; a miss ends the run
    task automatic wait_hi(input int lim, output int n);
        n = 0;
        while (rly[0] !== 1'b1) begin
            if (n >= lim) begin
                failures++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
                tally_and_finish();
            end
            @(posedge clk);
            n++;
        end
    endtask : wait_hi

    task automatic t_levels;
        lvl(6'h19, 14'h0000, 1'b0);
        lvl(6'h19, 14'h2000, 1'b1);
        lvl(6'h19, 14'h1000, 1'b1);
        lvl(6'h1b, 14'h2000, 1'b1);
        lvl(6'h1b, 14'h2800, 1'b0);
        lvl(6'h1b, 14'h0000, 1'b0);
        lvl(6'h2a, 14'h0020, 1'b1);
        lvl(6'h2a, 14'h3fdf, 1'b0);
        lvl(6'h2d, 14'h0404, 1'b1);
        lvl(6'h2d, 14'h0402, 1'b1);
        lvl(6'h2d, 14'h0004, 1'b0);
        lvl(6'h2b, 14'h0001, 1'b1);
        lvl(6'h2b, 14'h0018, 1'b1);
        lvl(6'h2b, 14'h0010, 1'b0);
        for (int c = 29; c <= 40; c++) lvl(6'(c), 14'h3fff, 1'b0);
        lvl(6'h00, 14'h3fff, 1'b0);
        lvl(6'h10, 14'h3fff, 1'b0);
        $display("levels done");
    endtask : t_levels

    // second pulse is stretched by four frozen cycles
    task automatic t_exit;
        int r;
        fn[0] <= 6'h1a;
        st    <= '0;
        cyc(3);
        r = rises;
        st.free_exit_trip <= 1'b1;
        cyc(20);
        #1;
        `CHK(rises, r + 1)
        `CHK(width, 5)
        @(posedge clk);
        st.free_exit_trip <= 1'b0;
        cyc(2);
        st.free_exit_trip <= 1'b1;
        cyc(3);
        ce <= 1'b0;
        cyc(4);
        ce <= 1'b1;
        cyc(15);
        #1;
        `CHK(rises, r + 2)
        `CHK(width, 9)
        $display("exit pulse done");
        @(posedge clk);
    endtask : t_exit

    task automatic t_test_open;
        int r;
        int n;
        fn[0] <= 6'h29;
        st    <= '0;
        cyc(3);
        r = rises;
        st.close_limit <= 1'b1;
        wait_hi(40, n);
        `CHK(n >= 20 && n <= 27, 1'b1)
        cyc(40);
        #1;
        `CHK(width, 5)
        `CHK(rises, r + 1)
        @(posedge clk);
        // a short visit to the close limit must not fire
        st.close_limit <= 1'b0;
        cyc(2);
        st.close_limit <= 1'b1;
        cyc(10);
        st.close_limit <= 1'b0;
        cyc(40);
        #1;
        `CHK(rises, r + 1)
        $display("test open done");
        @(posedge clk);
    endtask : t_test_open

    task automatic t_flash;
        int r;
        r     = rises;
        fn[0] <= 6'h1c;
        st    <= 14'h2000;
        cyc(30);
        #1;
        `CHK(width, 4)
        `CHK(rises - r >= 3, 1'b1)
        @(posedge clk);
        st.open_limit <= 1'b1;
        cyc(2);
        r = rises;
        cyc(20);
        #1;
        `CHK(rises, r)
        @(posedge clk);
        st <= 14'h0000;
        cyc(2);
        r = rises;
        cyc(20);
        #1;
        `CHK(rises, r)
        $display("flash done");
        @(posedge clk);
    endtask : t_flash

    task automatic t_partial;
        int r;
        fn[0] <= 6'h2c;
        st    <= 14'h0000;
        cyc(3);
        r = rises;
        st <= 14'h0200;
        cyc(15);
        #1;
        `CHK(rises, r)
        @(posedge clk);
        st <= 14'h0100;
        cyc(3);
        st <= 14'h0300;
        cyc(15);
        #1;
        `CHK(rises, r + 1)
        `CHK(width, 5)
        @(posedge clk);
        st <= 14'h0280;
        cyc(15);
        #1;
        `CHK(rises, r + 2)
        $display("partial done");
    endtask : t_partial

    // overall watchdog
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        tally_and_finish();
    end

    initial begin
        arst_n   = 1'b0;
        ce       = 1'b0;
        st       = '0;
        fn       = '0;
        failures = 0;
        compares = 0;
        cyc(4);
        arst_n <= 1'b1;
        ce     <= 1'b1;
        fn[1]  <= 6'h19;
        cyc(2);
        t_levels();
        t_exit();
        t_test_open();
        t_flash();
        t_partial();
        tally_and_finish();
    end
endmodule : testbench
